// *** verilog/swp_defines.svh ***
/*
  register offsets, reset values and address constants of the buffer window block.
  assumes inclusion by bare name from the design, the checker and the bench.
*/
`ifndef SWP_DEFINES_SVH
`define SWP_DEFINES_SVH
`define SWP_OFF_RX_START 12'h000
`define SWP_OFF_RX_RDPTR 12'h004
`define SWP_OFF_RX_WRPTR 12'h008
`define SWP_OFF_RX_DATA 12'h00C
`define SWP_OFF_UA_START 12'h010
`define SWP_OFF_UA_END 12'h014
`define SWP_OFF_UA_RDPTR 12'h018
`define SWP_OFF_UA_WRPTR 12'h01C
`define SWP_OFF_UA_DATA 12'h020
`define SWP_MEM_TOP 16'h5FFF
`define SWP_MEM_BOTTOM 16'h0000
`define SWP_MEM_DEPTH 24576
`define SWP_RX_START_RST 16'h5340
`define SWP_UA_START_RST 16'h0000
`define SWP_UA_END_RST 16'h0001
`define SWP_PTR_RST 16'h0000
`define SWP_RESP_OKAY 2'b00
`define SWP_RESP_SLVERR 2'b10
`endif

// *** verilog/swp_pkg.sv ***
/*
  types of the buffer window block.
  assumes swp_defines.svh is on the include path.
*/
package swp_pkg;
  typedef logic [15:0] swp_addr_t;
  typedef enum logic [2:0] {
    SWP_W_IDLE = 3'b001,
    SWP_W_RESP = 3'b010,
    SWP_W_DONE = 3'b100
  } swp_wst_e;
  typedef enum logic [2:0] {
    SWP_R_IDLE = 3'b001,
    SWP_R_MEM = 3'b010,
    SWP_R_RESP = 3'b100
  } swp_rst_e;
endpackage

// *** verilog/swp_window.sv ***
/*
  indirect byte-window access to the 24 kbyte packet buffer, receive and user-area
  pointer pairs, reached over an axi4-lite slave.
  assumes a single 100 MHz clock and a master that keeps one read and one write in flight.
*/
// Contract
// - rx window read, or write with byte 0 strobe set, bumps its pointer; from top of memory go to rx start.
// - user window read, or write with byte 0 strobe set, bumps its pointer by one byte.
// - user pointer equal to user end loads user start; this wins first.
// - user pointer at memory top, end elsewhere, goes to zero.
// - user end at memory top: pointer there goes to user start.
// - user start bit zero always reads zero.
// - user end bit zero always reads one.
// - user start and end writable at any time.
// - start above end skips addresses between end and start.
// - boundaries beyond memory never match; user pointers wrap top to zero.
// - user pointers ignore the rx start boundary.
// - window read returns byte at read pointer; write stores at write pointer.
// - reads move only read pointer, writes only write pointer.
// - rx start bit zero fixed zero, resets to 5340h.
`timescale 1ns/1ns
`include "swp_defines.svh"
module swp_window
  import swp_pkg::*;
(
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] mem_q [0:`SWP_MEM_DEPTH-1];
  swp_addr_t rx_area_start_address_q;
  swp_addr_t rx_area_read_pointer_q;
  swp_addr_t rx_area_write_pointer_q;
  swp_addr_t user_area_start_address_q;
  swp_addr_t user_area_end_address_q;
  swp_addr_t user_area_read_pointer_q;
  swp_addr_t user_area_write_pointer_q;
  swp_wst_e wst_q;
  swp_rst_e rst_q;
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [11:0] araddr_q;
  logic [7:0] mem_rd_q;
  logic [15:0] rd_ptr_q;

  // ----------------------------------------------------------------
  // pointer advance functions
  // ----------------------------------------------------------------
  function automatic swp_addr_t rx_next(input swp_addr_t p, input swp_addr_t st);
    if (p == `SWP_MEM_TOP) begin
      rx_next = st;
    end else begin
      rx_next = p + 16'h0001;
    end
  endfunction

  // full 16-bit compares: boundaries above memory never match
  function automatic swp_addr_t ua_next(input swp_addr_t p, input swp_addr_t st,
                                        input swp_addr_t nd);
    if (p == nd) begin
      ua_next = st;
    end else if (p == `SWP_MEM_TOP) begin
      ua_next = `SWP_MEM_BOTTOM;
    end else begin
      ua_next = p + 16'h0001;
    end
  endfunction

  // only addresses inside implemented memory index the array
  function automatic logic in_mem(input swp_addr_t p);
    in_mem = (p <= `SWP_MEM_TOP);
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic wr_go;
  assign wr_go = (wst_q == SWP_W_IDLE) && aw_have_q && w_have_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (wst_q == SWP_W_DONE) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else begin
        if (s_axi_awvalid && !aw_have_q && !s_axi_awready) begin
          s_axi_awready <= 1'b1;
        end
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q && !s_axi_wready) begin
          s_axi_wready <= 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= SWP_W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWP_RESP_OKAY;
    end else begin
      case (wst_q)
        SWP_W_IDLE: begin
          if (wr_go) begin
            wst_q <= SWP_W_RESP;
            s_axi_bvalid <= 1'b1;
            case (awaddr_q)
              `SWP_OFF_RX_START, `SWP_OFF_RX_RDPTR, `SWP_OFF_RX_WRPTR, `SWP_OFF_RX_DATA,
              `SWP_OFF_UA_START, `SWP_OFF_UA_END, `SWP_OFF_UA_RDPTR, `SWP_OFF_UA_WRPTR,
              `SWP_OFF_UA_DATA: s_axi_bresp <= `SWP_RESP_OKAY;
              default: s_axi_bresp <= `SWP_RESP_SLVERR;
            endcase
          end
        end
        SWP_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_q <= SWP_W_DONE;
          end
        end
        SWP_W_DONE: wst_q <= SWP_W_IDLE;
        default: wst_q <= SWP_W_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and pointers
  // ----------------------------------------------------------------
  logic lo_wr;
  logic rx_data_rd;
  logic ua_data_rd;
  assign lo_wr = wr_go && wstrb_q[0];
  assign rx_data_rd = (rst_q == SWP_R_IDLE) && s_axi_arvalid && s_axi_arready &&
                      (s_axi_araddr == `SWP_OFF_RX_DATA);
  assign ua_data_rd = (rst_q == SWP_R_IDLE) && s_axi_arvalid && s_axi_arready &&
                      (s_axi_araddr == `SWP_OFF_UA_DATA);

  // a 16-bit register takes bytes 0 and 1 by their own strobes
  function automatic swp_addr_t merge(input swp_addr_t old, input logic [31:0] d,
                                      input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_area_start_address_q <= `SWP_RX_START_RST;
      user_area_start_address_q <= `SWP_UA_START_RST;
      user_area_end_address_q <= `SWP_UA_END_RST;
    end else if (wr_go) begin
      case (awaddr_q)
        `SWP_OFF_RX_START:
          rx_area_start_address_q <= merge(rx_area_start_address_q, wdata_q, wstrb_q)
                                     & 16'hFFFE;
        `SWP_OFF_UA_START:
          user_area_start_address_q <= merge(user_area_start_address_q, wdata_q, wstrb_q)
                                       & 16'hFFFE;
        `SWP_OFF_UA_END:
          user_area_end_address_q <= merge(user_area_end_address_q, wdata_q, wstrb_q)
                                     | 16'h0001;
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_area_read_pointer_q <= `SWP_PTR_RST;
      user_area_read_pointer_q <= `SWP_PTR_RST;
    end else begin
      if (wr_go && awaddr_q == `SWP_OFF_RX_RDPTR) begin
        rx_area_read_pointer_q <= merge(rx_area_read_pointer_q, wdata_q, wstrb_q);
      end else if (rx_data_rd) begin
        rx_area_read_pointer_q <= rx_next(rx_area_read_pointer_q,
                                          rx_area_start_address_q);
      end
      if (wr_go && awaddr_q == `SWP_OFF_UA_RDPTR) begin
        user_area_read_pointer_q <= merge(user_area_read_pointer_q, wdata_q, wstrb_q);
      end else if (ua_data_rd) begin
        user_area_read_pointer_q <= ua_next(user_area_read_pointer_q,
          user_area_start_address_q, user_area_end_address_q);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_area_write_pointer_q <= `SWP_PTR_RST;
      user_area_write_pointer_q <= `SWP_PTR_RST;
    end else if (wr_go) begin
      case (awaddr_q)
        `SWP_OFF_RX_WRPTR:
          rx_area_write_pointer_q <= merge(rx_area_write_pointer_q, wdata_q, wstrb_q);
        `SWP_OFF_UA_WRPTR:
          user_area_write_pointer_q <= merge(user_area_write_pointer_q, wdata_q, wstrb_q);
        `SWP_OFF_RX_DATA:
          if (lo_wr) begin
            rx_area_write_pointer_q <= rx_next(rx_area_write_pointer_q,
                                               rx_area_start_address_q);
          end
        `SWP_OFF_UA_DATA:
          if (lo_wr) begin
            user_area_write_pointer_q <= ua_next(user_area_write_pointer_q,
              user_area_start_address_q, user_area_end_address_q);
          end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // buffer memory
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (lo_wr && awaddr_q == `SWP_OFF_RX_DATA && in_mem(rx_area_write_pointer_q)) begin
      mem_q[rx_area_write_pointer_q[14:0]] <= wdata_q[7:0];
    end else if (lo_wr && awaddr_q == `SWP_OFF_UA_DATA &&
                 in_mem(user_area_write_pointer_q)) begin
      mem_q[user_area_write_pointer_q[14:0]] <= wdata_q[7:0];
    end
    mem_rd_q <= in_mem(rd_ptr_q) ? mem_q[rd_ptr_q[14:0]] : 8'h00;
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_q <= SWP_R_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SWP_RESP_OKAY;
      araddr_q <= 12'h000;
      rd_ptr_q <= 16'h0000;
    end else begin
      s_axi_arready <= 1'b0;
      case (rst_q)
        SWP_R_IDLE: begin
          if (s_axi_arvalid && !s_axi_arready) begin
            s_axi_arready <= 1'b1;
          end
          if (s_axi_arvalid && s_axi_arready) begin
            araddr_q <= s_axi_araddr;
            rd_ptr_q <= (s_axi_araddr == `SWP_OFF_RX_DATA) ? rx_area_read_pointer_q
                                                          : user_area_read_pointer_q;
            rst_q <= SWP_R_MEM;
          end
        end
        SWP_R_MEM: begin
          rst_q <= SWP_R_RESP;
        end
        SWP_R_RESP: begin
          if (!s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SWP_RESP_OKAY;
            case (araddr_q)
              `SWP_OFF_RX_START: s_axi_rdata <= {16'h0000, rx_area_start_address_q};
              `SWP_OFF_RX_RDPTR: s_axi_rdata <= {16'h0000, rx_area_read_pointer_q};
              `SWP_OFF_RX_WRPTR: s_axi_rdata <= {16'h0000, rx_area_write_pointer_q};
              `SWP_OFF_UA_START: s_axi_rdata <= {16'h0000, user_area_start_address_q};
              `SWP_OFF_UA_END: s_axi_rdata <= {16'h0000, user_area_end_address_q};
              `SWP_OFF_UA_RDPTR: s_axi_rdata <= {16'h0000, user_area_read_pointer_q};
              `SWP_OFF_UA_WRPTR: s_axi_rdata <= {16'h0000, user_area_write_pointer_q};
              `SWP_OFF_RX_DATA, `SWP_OFF_UA_DATA:
                s_axi_rdata <= {24'h00_0000, mem_rd_q};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `SWP_RESP_SLVERR;
              end
            endcase
          end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rst_q <= SWP_R_IDLE;
          end
        end
        default: rst_q <= SWP_R_IDLE;
      endcase
    end
  end

endmodule

// *** sim/swp_window_sva.sv ***
/*
  checker: read and write answer timing and readback shape of the window block.
  assumes a bind to swp_window and the defines header on the include path.
*/
`timescale 1ns/1ns
`include "swp_defines.svh"
module swp_window_chk
  import swp_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // read response
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready // b ready
);
  // ----------------------------------------
  // address of the read in flight
  // ----------------------------------------
  logic [11:0] ra_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_q <= 12'h000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ra_q <= s_axi_araddr;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_RD_LATENCY: assert property (s_axi_arvalid && s_axi_arready |-> ##3 s_axi_rvalid)
    else $error("read answer late");
  AST_WR_LATENCY: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> !s_axi_bvalid ##2 s_axi_bvalid) else $error("write answer off");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  AST_WIN_BYTE: assert property (s_axi_rvalid && (ra_q == `SWP_OFF_RX_DATA ||
    ra_q == `SWP_OFF_UA_DATA) |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("wide window");
  AST_REG_WIDTH: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half set");
  AST_UA_START_EVEN: assert property (s_axi_rvalid && ra_q == `SWP_OFF_UA_START
    |-> !s_axi_rdata[0]) else $error("user start odd");
  AST_UA_END_ODD: assert property (s_axi_rvalid && ra_q == `SWP_OFF_UA_END
    |-> s_axi_rdata[0]) else $error("user end even");
  AST_RX_START_EVEN: assert property (s_axi_rvalid && ra_q == `SWP_OFF_RX_START
    |-> !s_axi_rdata[0]) else $error("rx start odd");
endmodule
bind swp_window swp_window_chk chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));

// *** sim/swp_host.sv ***
/*
  host model: axi4-lite master with one write and one read task.
  assumes the caller enters a task right after a rising edge.
*/
`timescale 1ns/1ns
module swp_host (
  input wire logic aclk, // clock
  output logic [11:0] awaddr, // aw addr
  output logic awvalid, // aw valid
  input wire logic awready, // aw ready
  output logic [31:0] wdata, // w data
  output logic [3:0] wstrb, // w strobes
  output logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic [1:0] bresp, // b resp
  input wire logic bvalid, // b valid
  output logic bready, // b ready
  output logic [11:0] araddr, // ar addr
  output logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic [31:0] rdata, // r data
  input wire logic [1:0] rresp, // r resp
  input wire logic rvalid, // r valid
  output logic rready // r ready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= '0;
    {araddr, arvalid, rready} <= '0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input int lag, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // late ready keeps the answer standing, for the hold checks
    repeat (lag) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input int lag, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    repeat (lag) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// *** sim/swp_window_bench.sv ***
/*
  testbench of the buffer window block: pointer wraps, lsb forcing, byte lanes.
  assumes swp_host as bus master and the bound checker.
*/
`timescale 1ns/1ns
`include "swp_defines.svh"
module swp_window_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] dt;
  int fails, samples_checked;
  // start, end, pointer, expected next pointer
  localparam logic [63:0] UA_TAB [7] = '{64'h0100_01FF_0150_0151, 64'h0100_01FF_01FF_0100,
    64'h0100_01FF_5FFF_0000, 64'h0200_5FFF_5FFF_0200, 64'h4000_1001_1001_4000,
    64'h6000_6001_5FFF_0000, 64'h6000_6001_533F_5340};
  swp_window dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  swp_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task summarize;
    $display("mismatches %0d comparisons %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp_data(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: data %h, expected %h", $time, g, e);
    end
  endtask
  task cmp_resp(input logic [1:0] g, input logic [1:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: response %b, expected %b", $time, g, e);
    end
  endtask
  task wo(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    host.wr(a, d, s, 0, rs);
    cmp_resp(rs, `SWP_RESP_OKAY);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    host.rd(a, 0, dt, rs);
    cmp_resp(rs, `SWP_RESP_OKAY);
    cmp_data(dt, e);
  endtask
  task t_reset;
    rc(`SWP_OFF_RX_START, 32'h0000_5340);
    rc(`SWP_OFF_UA_START, 32'h0000_0000);
    rc(`SWP_OFF_UA_END, 32'h0000_0001);
    rc(`SWP_OFF_UA_RDPTR, 32'h0000_0000);
  endtask
  task t_lsb;
    wo(`SWP_OFF_UA_START, 32'h0000_1235, 4'b0011);
    rc(`SWP_OFF_UA_START, 32'h0000_1234);
    wo(`SWP_OFF_UA_START, 32'hFFFF_ABCC, 4'b0001);
    rc(`SWP_OFF_UA_START, 32'h0000_12CC);
    wo(`SWP_OFF_UA_END, 32'h0000_1234, 4'b0011);
    rc(`SWP_OFF_UA_END, 32'h0000_1235);
    wo(`SWP_OFF_RX_START, 32'h0000_5341, 4'b0011);
    rc(`SWP_OFF_RX_START, 32'h0000_5340);
  endtask
  task t_rx;
    wo(`SWP_OFF_RX_WRPTR, 32'h0000_5FFF, 4'b0011);
    wo(`SWP_OFF_RX_DATA, 32'h0000_00A5, 4'b0001);
    wo(`SWP_OFF_RX_DATA, 32'h0000_005A, 4'b0001);
    rc(`SWP_OFF_RX_WRPTR, 32'h0000_5341);
    wo(`SWP_OFF_RX_RDPTR, 32'h0000_5FFF, 4'b0011);
    rc(`SWP_OFF_RX_DATA, 32'h0000_00A5);
    rc(`SWP_OFF_RX_DATA, 32'h0000_005A);
    rc(`SWP_OFF_RX_RDPTR, 32'h0000_5341);
    rc(`SWP_OFF_RX_WRPTR, 32'h0000_5341);
  endtask
  task t_ua;
    for (int i = 0; i < 7; i++) begin
      wo(`SWP_OFF_UA_START, {16'h0000, UA_TAB[i][63:48]}, 4'b0011);
      wo(`SWP_OFF_UA_END, {16'h0000, UA_TAB[i][47:32]}, 4'b0011);
      wo(`SWP_OFF_UA_WRPTR, {16'h0000, UA_TAB[i][31:16]}, 4'b0011);
      wo(`SWP_OFF_UA_RDPTR, {16'h0000, UA_TAB[i][31:16]}, 4'b0011);
      wo(`SWP_OFF_UA_DATA, 32'h0000_0040 + 32'(i), 4'b0001);
      rc(`SWP_OFF_UA_RDPTR, {16'h0000, UA_TAB[i][31:16]});
      rc(`SWP_OFF_UA_DATA, 32'h0000_0040 + 32'(i));
      rc(`SWP_OFF_UA_RDPTR, {16'h0000, UA_TAB[i][15:0]});
      rc(`SWP_OFF_UA_WRPTR, {16'h0000, UA_TAB[i][15:0]});
    end
  endtask
  task t_lane;
    wo(`SWP_OFF_UA_WRPTR, 32'h0000_0010, 4'b0011);
    wo(`SWP_OFF_UA_DATA, 32'h0000_7700, 4'b0010);
    rc(`SWP_OFF_UA_WRPTR, 32'h0000_0010);
    host.wr(12'h040, 32'h0000_1111, 4'b0011, 0, rs);
    cmp_resp(rs, `SWP_RESP_SLVERR);
    host.rd(12'h040, 0, dt, rs);
    cmp_resp(rs, `SWP_RESP_SLVERR);
    cmp_data(dt, 32'h0000_0000);
  endtask
  // late bready and rready: answers must stand until taken
  task t_slow;
    host.wr(`SWP_OFF_UA_START, 32'h0000_0301, 4'b0011, 4, rs);
    cmp_resp(rs, `SWP_RESP_OKAY);
    host.rd(`SWP_OFF_UA_START, 4, dt, rs);
    cmp_resp(rs, `SWP_RESP_OKAY);
    cmp_data(dt, 32'h0000_0300);
  endtask
  initial begin
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_lsb();
    t_rx();
    t_ua();
    t_lane();
    t_slow();
    summarize();
  end
  // whole run needs well under 2000 cycles
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule
